/* verilog/fic_params.svh */
/*
 Constants of the flash identification and reset command block.
 Assumes inclusion by bare name from the design and the testbench.
*/
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH
`define FIC_OP_STD_ID      8'h9f
`define FIC_OP_STD_ID_Q    8'haf
`define FIC_OP_MD_ID       8'h90
`define FIC_OP_UNIQ        8'h4b
`define FIC_OP_PARAM_TBL   8'h5a
`define FIC_OP_NOP         8'h00
`define FIC_OP_RST_ARM     8'h66
`define FIC_OP_RST         8'h99
`define FIC_OP_ROW_PROG    8'h62
`define FIC_PARAM_DUMMY    4'd8
`define FIC_UNIQ_DUMMY_DEF 4'd8
`define FIC_RESET_MIN_NS   100
`define FIC_RECOV_US       35
`define FIC_MCLK_NS        40
`define FIC_RESET_MIN_CYC  ((`FIC_RESET_MIN_NS + `FIC_MCLK_NS - 1) / `FIC_MCLK_NS)
`define FIC_RECOV_CYC      ((`FIC_RECOV_US * 1000 + `FIC_MCLK_NS - 1) / `FIC_MCLK_NS)
`define FIC_ROW_LOCK_LSB   4
`define FIC_ROW_HI_BYTE    8'h00
`endif

/* verilog/fic_pkg.sv */
/*
 Types of the flash identification and reset command block.
 Assumes fic_params.svh on the include path.
*/
package fic_pkg;
  typedef enum logic [2:0] {
    FIC_PH_OPC,
    FIC_PH_ADDR,
    FIC_PH_DUMMY,
    FIC_PH_DATA,
    FIC_PH_IGNORE
  } fic_phase_t;
endpackage : fic_pkg

/* verilog/fic_cmd.sv */
/*
 Flash command interpreter for ID reads, parameter table, no-op, resets and row program gate.
 Assumes serial clock frames from a host controller; the core clock i_mclk runs at 25 MHz.
*/
// Summary of operation
// - Standard ID opcode, also quad alternate in QPI mode only, sends maker byte then two-byte type ID.
// - Standard ID sequence loops from maker byte while chip enable stays low.
// - ID output bits change on falling serial clock edges.
// - Maker/device ID takes three address bytes and no dummy clocks on rising edges.
// - Address bit 0 zero sends maker first, one sends device byte first.
// - Maker/device ID bytes alternate while chip enable stays low.
// - Unique ID read takes address and dummy clocks then sixteen factory bytes.
// - Unique ID bytes wrap back to byte zero after the sixteenth.
// - Unique ID byte index is address bits three to zero; higher bits ignored.
// - Parameter table read takes address and eight dummy cycles then streams table data.
// - No-op cancels a pending reset arm and nothing else.
// - Reset arm then reset in next frame; any other command disarms.
// - Any reset reloads volatile registers from non-volatile copies.
// - Status and function registers are untouched by reset.
// - Shared reset pin honoured only in SPI mode with quad enable clear.
// - Dedicated reset pin honoured in every mode unless disabled.
// - Reset pin held long enough aborts work, leaves power-down, floats outputs.
// - No instruction accepted during reset recovery time.
// - Reset during program or erase aborts that operation.
// - Row program rejected while a write cycle is busy.
// - Security rows decode from address bits fifteen to eight, upper byte zero.
// - Row lock bits seven to four make rows read-only once set.
// - Shared pin select bit chooses reset or hold function.
`timescale 1ns/1ps
`include "fic_params.svh"
module fic_cmd #(
  parameter logic [7:0]  MAKER_ID    = 8'h5a,   // Arbitrary value
  parameter logic [15:0] TYPE_CAP_ID = 16'h1234, // Arbitrary value
  parameter logic [7:0]  DEVICE_ID   = 8'h33,   // Arbitrary value
  parameter logic [127:0] UNIQUE_NUM = 128'h0123456789abcdeffedcba9876543210,
  parameter int          TBL_BYTES   = 16,
  parameter int          RECOV_CYC   = `FIC_RECOV_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic        i_rst_pin_n,
  input  wire logic        i_dedicated_rst,
  input  wire logic        i_qpi_mode,
  input  wire logic        i_quad_enable_bit,
  input  wire logic        i_shared_pin_select_bit,
  input  wire logic [7:0]  i_func_reg,
  input  wire logic        i_write_busy_flag,
  input  wire logic [3:0]  i_uniq_dummy,
  output logic             o_so,
  output logic             o_so_oe,
  output logic             o_hold_active,
  output logic             o_reload_volatile,
  output logic             o_abort_write,
  output logic             o_leave_power_down,
  output logic             o_busy_recover,
  output logic             o_row_prog_ok,
  output logic [1:0]       o_row_sel,
  output logic             o_reset_armed
);
  import fic_pkg::*;

  function automatic logic [7:0] tbl_byte(input logic [23:0] a);
    // Outside the table a fixed pattern keeps reads stable and side-effect free
    tbl_byte = (a < 24'(TBL_BYTES)) ? a[7:0] ^ 8'h53 : 8'hff;
  endfunction : tbl_byte

  // ---------------- Link domain (serial clock) ----------------
  fic_phase_t  ph_r;
  logic [7:0]  opc_r;
  logic [23:0] addr_r;
  logic [5:0]  cnt_r;
  logic [7:0]  obyte_r;
  logic [2:0]  bit_r;
  logic [4:0]  bidx_r;
  logic        frame_tgl_r;
  logic [7:0]  frame_opc_r;
  logic [23:0] frame_addr_r;
  logic [7:0]  sh_nxt;
  logic        blocked_s1_r;
  logic        blocked_s2_r;
  logic [3:0]  dummy_n;
  logic [7:0]  load_byte;

  assign sh_nxt  = {opc_r[6:0], i_si};
  assign dummy_n = (opc_r == `FIC_OP_UNIQ) ? i_uniq_dummy :
                   (opc_r == `FIC_OP_MD_ID) ? 4'd0 : `FIC_PARAM_DUMMY;

  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      blocked_s1_r <= 1'b0;
      blocked_s2_r <= 1'b0;
    end else begin
      blocked_s1_r <= o_busy_recover;
      blocked_s2_r <= blocked_s1_r;
    end
  end

  function automatic logic [7:0] next_byte(input logic [7:0] op, input logic [23:0] a,
                                           input logic [4:0] k);
    case (op)
      `FIC_OP_STD_ID, `FIC_OP_STD_ID_Q:
        next_byte = (k % 5'd3 == 5'd0) ? MAKER_ID :
                    (k % 5'd3 == 5'd1) ? TYPE_CAP_ID[15:8] : TYPE_CAP_ID[7:0];
      `FIC_OP_MD_ID:
        next_byte = (k[0] ^ a[0]) ? DEVICE_ID : MAKER_ID;
      `FIC_OP_UNIQ:
        next_byte = UNIQUE_NUM[8'd127 - {(a[3:0] + k[3:0]), 3'b000} -: 8];
      `FIC_OP_PARAM_TBL:
        next_byte = tbl_byte(a + 24'(k));
      default:
        next_byte = 8'hff;
    endcase
  endfunction : next_byte
  assign load_byte = next_byte(opc_r, addr_r, bidx_r);

  // Inputs latched on rising edges; frame restarts when chip enable rises
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      ph_r   <= FIC_PH_OPC;
      opc_r  <= 8'h00;
      addr_r <= 24'h0;
      cnt_r  <= 6'd0;
      bidx_r <= 5'd0;
    end else begin
      case (ph_r)
        FIC_PH_OPC: begin
          opc_r <= sh_nxt;
          cnt_r <= cnt_r + 6'd1;
          if (cnt_r == 6'd7) begin
            cnt_r <= 6'd0;
            if (blocked_s2_r)
              ph_r <= FIC_PH_IGNORE;
            else if (sh_nxt == `FIC_OP_STD_ID ||
                     (sh_nxt == `FIC_OP_STD_ID_Q && i_qpi_mode))
              ph_r <= FIC_PH_DATA;
            else if (sh_nxt == `FIC_OP_MD_ID || sh_nxt == `FIC_OP_UNIQ ||
                     sh_nxt == `FIC_OP_PARAM_TBL || sh_nxt == `FIC_OP_ROW_PROG)
              ph_r <= FIC_PH_ADDR;
            else
              ph_r <= FIC_PH_IGNORE;
          end
        end
        FIC_PH_ADDR: begin
          addr_r <= {addr_r[22:0], i_si};
          cnt_r  <= cnt_r + 6'd1;
          if (cnt_r == 6'd23) begin
            cnt_r <= 6'd0;
            if (opc_r == `FIC_OP_ROW_PROG)
              ph_r <= FIC_PH_IGNORE;
            else if (dummy_n == 4'd0)
              ph_r <= FIC_PH_DATA;
            else
              ph_r <= FIC_PH_DUMMY;
          end
        end
        FIC_PH_DUMMY: begin
          cnt_r <= cnt_r + 6'd1;
          if (cnt_r == 6'({2'b00, dummy_n} - 6'd1)) begin
            cnt_r <= 6'd0;
            ph_r  <= FIC_PH_DATA;
          end
        end
        FIC_PH_DATA: begin
          cnt_r <= cnt_r + 6'd1;
          if (cnt_r[2:0] == 3'd7) begin
            bidx_r <= (opc_r == `FIC_OP_STD_ID || opc_r == `FIC_OP_STD_ID_Q) &&
                      bidx_r == 5'd2 ? 5'd0 : bidx_r + 5'd1;
          end
        end
        default: ph_r <= FIC_PH_IGNORE;
      endcase
    end
  end

  // Output shifts on falling edges so the host samples on the next rise
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
      obyte_r <= 8'h00;
      bit_r   <= 3'd0;
    end else if (ph_r == FIC_PH_DATA && !blocked_s2_r) begin
      o_so_oe <= 1'b1;
      bit_r   <= bit_r + 3'd1;
      if (bit_r == 3'd0) begin
        obyte_r <= load_byte;
        o_so    <= load_byte[7];
      end else begin
        o_so <= obyte_r[3'd7 - bit_r];
      end
    end else begin
      o_so_oe <= 1'b0;
    end
  end

  // Frame end report: opcode captured when the frame closes, toggle for the core
  always_ff @(posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_tgl_r  <= 1'b0;
      frame_opc_r  <= 8'h00;
      frame_addr_r <= 24'h0;
    end else if (!blocked_s2_r) begin
      frame_tgl_r  <= ~frame_tgl_r;
      frame_opc_r  <= (ph_r == FIC_PH_OPC) ? 8'h01 : opc_r;
      // Held here because the link address clears as chip enable rises
      frame_addr_r <= addr_r;
    end
  end

  // ---------------- Core domain ----------------
  logic        tgl_s1_r;
  logic        tgl_s2_r;
  logic        tgl_s3_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic [2:0]  low_cnt_r;
  logic [$clog2(RECOV_CYC+1)-1:0] rec_cnt_r;
  logic        pin_rst_evt;
  logic        sw_rst_evt;
  logic        pin_enabled;
  logic        frame_evt;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else if (i_ce) begin
      tgl_s1_r <= frame_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      pin_s1_r <= i_rst_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign frame_evt   = i_ce && (tgl_s2_r ^ tgl_s3_r);
  assign pin_enabled = i_dedicated_rst ? !i_func_reg[0] :
                       (!i_qpi_mode && !i_quad_enable_bit && i_shared_pin_select_bit);
  assign o_hold_active = !i_dedicated_rst && !i_shared_pin_select_bit;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      low_cnt_r <= 3'd0;
    else if (i_ce) begin
      if (pin_s2_r || !pin_enabled)
        low_cnt_r <= 3'd0;
      else if (low_cnt_r != 3'(`FIC_RESET_MIN_CYC))
        low_cnt_r <= low_cnt_r + 3'd1;
    end
  end

  assign pin_rst_evt = i_ce && pin_enabled && pin_s2_r &&
                       low_cnt_r == 3'(`FIC_RESET_MIN_CYC);
  assign sw_rst_evt  = frame_evt && o_reset_armed && frame_opc_r == `FIC_OP_RST;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_reset_armed <= 1'b0;
    else if (frame_evt)
      o_reset_armed <= (frame_opc_r == `FIC_OP_RST_ARM);
    else if (pin_rst_evt)
      o_reset_armed <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reload_volatile  <= 1'b0;
      o_abort_write      <= 1'b0;
      o_leave_power_down <= 1'b0;
    end else if (i_ce) begin
      // Only volatile copies reload; status and function registers stay outside
      o_reload_volatile  <= pin_rst_evt || sw_rst_evt;
      o_abort_write      <= (pin_rst_evt || sw_rst_evt) && i_write_busy_flag;
      o_leave_power_down <= pin_rst_evt;
    end
  end

  // Recovery also counts low pin time so a long pulse holds instructions off
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      rec_cnt_r <= '0;
    else if (i_ce) begin
      if (pin_rst_evt || (pin_enabled && !pin_s2_r))
        rec_cnt_r <= ($clog2(RECOV_CYC+1))'(RECOV_CYC);
      else if (rec_cnt_r != '0)
        rec_cnt_r <= rec_cnt_r - 1'b1;
    end
  end
  assign o_busy_recover = rec_cnt_r != '0;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_row_prog_ok <= 1'b0;
      o_row_sel     <= 2'd0;
    end else if (frame_evt) begin
      o_row_sel     <= frame_addr_r[13:12];
      o_row_prog_ok <= frame_opc_r == `FIC_OP_ROW_PROG && !i_write_busy_flag &&
                       frame_addr_r[23:16] == `FIC_ROW_HI_BYTE &&
                       frame_addr_r[11:8] == 4'h0 &&
                       frame_addr_r[15:14] == 2'b00 &&
                       !i_func_reg[`FIC_ROW_LOCK_LSB + frame_addr_r[13:12]];
    end else if (i_ce) begin
      o_row_prog_ok <= 1'b0;
    end
  end

  a_arm_cleared: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    frame_evt && frame_opc_r != `FIC_OP_RST_ARM |=> !o_reset_armed)
    else $error("reset arm survived another command");
  a_nop_disarms: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    frame_evt && frame_opc_r == `FIC_OP_NOP |=> !o_reset_armed)
    else $error("no-op did not disarm reset");
  a_sw_reset_reload: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ce && sw_rst_evt |=> o_reload_volatile)
    else $error("software reset did not reload");
  a_pin_recovery: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pin_rst_evt |=> o_busy_recover [*8])
    else $error("recovery window too short");
  a_pin_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ce && !pin_enabled |=> !o_leave_power_down)
    else $error("reset pin acted while disabled");
  a_power_down_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ce && pin_rst_evt |=> o_leave_power_down)
    else $error("pin reset did not leave power-down");
  a_arm_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    frame_evt && frame_opc_r == `FIC_OP_RST_ARM |=> o_reset_armed)
    else $error("reset arm frame did not arm");
  a_abort_only_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ce && !i_write_busy_flag |=> !o_abort_write)
    else $error("abort raised with no write running");
  a_row_lock: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_row_prog_ok |-> !i_func_reg[`FIC_ROW_LOCK_LSB + o_row_sel])
    else $error("locked row programmable");
  a_row_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    frame_evt && i_write_busy_flag |=> !o_row_prog_ok)
    else $error("row program accepted while busy");
  a_abort_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ce && pin_rst_evt && i_write_busy_flag |=> o_abort_write)
    else $error("write not aborted by reset");
  c_sw_reset: cover property (@(posedge i_mclk) disable iff (!i_rst_n) sw_rst_evt);
  c_pin_reset: cover property (@(posedge i_mclk) disable iff (!i_rst_n) pin_rst_evt);
  c_row_ok: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_row_prog_ok);
  c_arm: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_reset_armed);
endmodule : fic_cmd

/* bench/fic_host_model.sv */
/*
 Host flash controller model: chip enable, serial clock and data in.
 Assumes mode 0 framing; the serial clock stands low between frames.
*/
`timescale 1ns/1ps
module fic_host_model (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  logic [7:0] rx_q[$];
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  task automatic send_bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si  = v[i];
      #3 o_sck = 1'b1;
      #3;
    end
  endtask : send_bits
  // Opcode, address, dummy clocks, then nout bytes read MSB first
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int na,
                       input int nd, input int nout);
    logic [7:0] b;
    rx_q   = {};
    o_cs_n = 1'b0;
    #3;
    send_bits({24'h0, op}, 8);
    send_bits({8'h0, adr}, na);
    send_bits(32'h0, nd);
    for (int k = 0; k < nout; k++) begin
      for (int i = 7; i >= 0; i--) begin
        o_sck = 1'b0;
        #3 o_sck = 1'b1;
        b[i] = i_so;
        #3;
      end
      rx_q.push_back(b);
    end
    o_sck = 1'b0;
    #3 o_cs_n = 1'b1;
    // Released line must not keep its last value
    o_si = ~o_si;
  endtask : frame
endmodule : fic_host_model

/* bench/fic_cmd_tb_top.sv */
/*
 Testbench of the identification and reset command block.
 Assumes the host model drives the link side; expectations come from queues.
*/
`timescale 1ns/1ps
`include "fic_params.svh"
module fic_cmd_tb_top;
  localparam logic [7:0]   MK = 8'h5a;  // Arbitrary value
  localparam logic [15:0]  TC = 16'h1234; // Arbitrary value
  localparam logic [7:0]   DV = 8'h33;  // Arbitrary value
  localparam logic [127:0] UN = 128'h0123456789abcdeffedcba9876543210;
  logic i_mclk = 0, i_rst_n = 0, i_ce = 1, i_rst_pin_n = 1, i_dedicated_rst = 0;
  logic i_qpi_mode = 0, i_quad_enable_bit = 0, i_shared_pin_select_bit = 0;
  logic i_write_busy_flag = 0, i_sck, i_cs_n, i_si;
  logic [7:0] i_func_reg = 8'h00;
  logic [3:0] i_uniq_dummy = 4'h8;
  logic o_so, o_so_oe, o_hold_active, o_reload_volatile, o_abort_write;
  logic o_leave_power_down, o_busy_recover, o_row_prog_ok, o_reset_armed;
  logic [1:0] o_row_sel, row_v;
  logic [7:0] exp_q[$], bt;
  logic [23:0] a;
  logic [31:0] x = 32'd70, r;
  int errors = 0, tests_run = 0, rl_n = 0, ab_n = 0, pd_n = 0, ok_n = 0;
  int rl0, ab0, pd0, ok0, e, oe_n = 0;
  logic [5:0] pcfg[5] = '{6'b100111, 6'b111000, 6'b001001, 6'b001100, 6'b001010};

  always #20 i_mclk = ~i_mclk;
  fic_host_model host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so));
  fic_cmd #(.MAKER_ID(MK), .TYPE_CAP_ID(TC), .DEVICE_ID(DV), .UNIQUE_NUM(UN),
            .TBL_BYTES(16), .RECOV_CYC(20)) uut (.i_mclk, .i_rst_n, .i_ce, .i_sck,
    .i_cs_n, .i_si, .i_rst_pin_n, .i_dedicated_rst, .i_qpi_mode, .i_quad_enable_bit,
    .i_shared_pin_select_bit, .i_func_reg, .i_write_busy_flag, .i_uniq_dummy, .o_so,
    .o_so_oe, .o_hold_active, .o_reload_volatile, .o_abort_write, .o_leave_power_down,
    .o_busy_recover, .o_row_prog_ok, .o_row_sel, .o_reset_armed);

  always @(posedge i_sck) begin
    if (o_so_oe === 1'b1) oe_n++;
  end

  always @(posedge i_mclk) begin
    if (o_reload_volatile === 1'b1) rl_n++;
    if (o_abort_write === 1'b1) ab_n++;
    if (o_leave_power_down === 1'b1) pd_n++;
    if (o_row_prog_ok === 1'b1) begin
      ok_n++;
      row_v = o_row_sel;
    end
  end

  function automatic logic [31:0] nxt();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    tests_run++;
    if (s !== ex) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  // Frames stay at least four core cycles apart
  task automatic gap();
    repeat (6) @(negedge i_mclk);
  endtask : gap
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input int na);
    host.frame(op, ad, na, 0, 0);
    gap();
  endtask : cmd
  task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int na, input int nd);
    oe_n = 0;
    host.frame(op, ad, na, nd, exp_q.size());
    foreach (exp_q[i]) chk("so byte", exp_q[i], host.rx_q[i]);
    chk("so oe", 8 * exp_q.size(), oe_n);
    gap();
  endtask : rd
  task automatic pin_low();
    @(negedge i_mclk);
    i_rst_pin_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_rst_pin_n = 1'b1;
    repeat (4) @(negedge i_mclk);
  endtask : pin_low
  // Host waits out the recovery before the next instruction
  task automatic pin_wait();
    for (int i = 0; i < 60 && o_busy_recover !== 1'b0; i++) @(negedge i_mclk);
    chk("recover end", 0, o_busy_recover);
    gap();
  endtask : pin_wait
  task automatic wrap_up();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #400000;
    errors++;
    wrap_up();
  end

  initial begin
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    gap();
    for (int m = 0; m < 2; m++) begin
      i_qpi_mode = m[0];
      exp_q = {};
      repeat (2) exp_q = {exp_q, MK, TC[15:8], TC[7:0]};
      rd(m ? `FIC_OP_STD_ID_Q : `FIC_OP_STD_ID, 24'h0, 0, 0);
      r = nxt();
      exp_q = {};
      repeat (2) exp_q = m ? {exp_q, DV, MK} : {exp_q, MK, DV};
      rd(`FIC_OP_MD_ID, {16'h0, r[7:1], m[0]}, 24, 0);
      a = m ? {16'h0, 2'b10, r[13:8]} : 24'h00000e;
      exp_q = {};
      for (int i = 0; i < 4; i++) begin
        bt = a[7:0] + i[7:0];
        exp_q.push_back(bt < 8'd16 ? bt ^ 8'h53 : 8'hff);
      end
      rd(`FIC_OP_PARAM_TBL, a, 24, `FIC_PARAM_DUMMY);
    end
    i_qpi_mode = 1'b0;
    r = nxt();
    exp_q = {};
    for (int i = 0; i < 18; i++) exp_q.push_back(UN[127 - 8 * ((r[3:0] + i) % 16) -: 8]);
    rd(`FIC_OP_UNIQ, {r[23:9], 5'h0, r[3:0]}, 24, 8);
    for (int m = 0; m < 3; m++) begin
      rl0 = rl_n;
      cmd(`FIC_OP_RST_ARM, 24'h0, 0);
      chk("armed", 1, o_reset_armed);
      if (m < 2) cmd(m ? `FIC_OP_STD_ID : `FIC_OP_NOP, 24'h0, 0);
      cmd(`FIC_OP_RST, 24'h0, 0);
      chk("sw reset", rl0 + (m == 2), rl_n);
    end
    {i_dedicated_rst, i_write_busy_flag} = 2'b11;
    {rl0, ab0, pd0} = {rl_n, ab_n, pd_n};
    pin_low();
    chk("recover", 1, o_busy_recover);
    chk("abort", ab0 + 1, ab_n);
    chk("power up", pd0 + 1, pd_n);
    chk("reload", rl0 + 1, rl_n);
    cmd(`FIC_OP_RST_ARM, 24'h0, 0);
    chk("armed", 0, o_reset_armed);
    pin_wait();
    cmd(`FIC_OP_RST, 24'h0, 0);
    chk("reload", rl0 + 1, rl_n);
    for (int k = 0; k < 5; k++) begin
      @(negedge i_mclk);
      {i_dedicated_rst, i_func_reg[0], i_shared_pin_select_bit, i_quad_enable_bit,
       i_qpi_mode} = pcfg[k][5:1];
      e = pcfg[k][0];
      rl0 = rl_n;
      pin_low();
      pin_wait();
      chk("pin reset", rl0 + e, rl_n);
    end
    i_shared_pin_select_bit = 1'b0;
    #1 chk("hold", 1, o_hold_active);
    i_qpi_mode = 1'b0;
    for (int k = 0; k < 6; k++) begin
      @(negedge i_mclk);
      r = nxt();
      i_func_reg = {r[7:4], 4'h0};
      i_write_busy_flag = (k == 5);
      a = {8'h00, (k == 4) ? 8'h40 : {2'b00, k[1:0], 4'h0}, r[23:16]};
      e = (k < 4) && !r[4 + k[1:0]];
      ok0 = ok_n;
      cmd(`FIC_OP_ROW_PROG, a, 24);
      chk("row ok", ok0 + e, ok_n);
      if (e) chk("row sel", k[1:0], row_v);
    end
    wrap_up();
  end
endmodule : fic_cmd_tb_top
